//--- hw/ctsa_pkg.sv
// Purpose: Shared constants, types and helpers of the tag link.
// Assumes: Characters are start bit 0, eight data bits LSB first, stop bit 1.
// Notes:   Command codes below are local encodings of this design.
package ctsa_pkg;
	localparam int          CHAR_BITS     = 10;
	localparam int          FRAME_MAX     = 8;
	localparam int          LINK_HALF_DEF = 8;
	localparam logic [3:0]  MIN_FRAME     = 4'h3;
	localparam logic [3:0]  CHOOSE_FRAME  = 4'h4;
	localparam logic [7:0]  CMD_BEGIN_INV = 8'h01;
	localparam logic [7:0]  CMD_SLOT_ZERO = 8'h02;
	localparam logic [3:0]  CMD_SLOT_HI   = 4'h1;
	localparam logic [7:0]  CMD_CHOOSE    = 8'h04;
	localparam logic [7:0]  CMD_FINISH    = 8'h05;
	localparam logic [7:0]  CMD_ROUNDUP   = 8'h06;
	localparam logic [7:0]  CMD_FETCH     = 8'h07;
	localparam logic [7:0]  CMD_STORE     = 8'h08;
	localparam logic [7:0]  CMD_UID       = 8'h09;
	localparam logic [15:0] CRC_INIT      = 16'hffff;
	localparam logic [15:0] CRC_POLY      = 16'h8408;
	localparam logic [15:0] LFSR_SEED     = 16'hace1;
	localparam logic [15:0] LFSR_TAPS     = 16'hb400;
	localparam logic [7:0]  ID_RESET      = 8'h00;

	typedef enum logic [2:0] {
		ST_OFF   = 3'b000,
		ST_READY = 3'b001,
		ST_INV   = 3'b010,
		ST_SEL   = 3'b011,
		ST_DESEL = 3'b100,
		ST_DEACT = 3'b101
	} ctsa_state_t;

	typedef enum logic [1:0] {
		PH_DATA = 2'b00,
		PH_CRCL = 2'b01,
		PH_CRCH = 2'b10,
		PH_END  = 2'b11
	} ctsa_phase_t;

	// Reflected CRC without final inversion: a good frame leaves a zero residue.
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc_step
endpackage : ctsa_pkg

//--- hw/ctsa_link_if.sv
// Purpose: Serial link between reader end and tag end.
// Assumes: The reader end makes link_clk; both ends sample it with ref_clk.
// Notes:   Frame lines high mark a frame: rising edge opens, falling edge closes.
`timescale 1ns/1ps
interface ctsa_link_if;
	logic link_clk;
	logic rd_frame;
	logic rd_data;
	logic tg_frame;
	logic tg_data;
	modport reader (output link_clk, output rd_frame, output rd_data,
		input tg_frame, input tg_data);
	modport tag (input link_clk, input rd_frame, input rd_data,
		output tg_frame, output tg_data);
endinterface : ctsa_link_if

//--- hw/ctsa_tag_end.sv
// Purpose: Tag end: frame check, state machine, anticollision and replies.
// Assumes: rst_n low while the field is absent; link pins are asynchronous.
// Notes:   A new request must not arrive while a memory request is forwarded.
`timescale 1ns/1ps
module ctsa_tag_end (
	input  wire logic                 ref_clk,
	input  wire logic                 rst_n,
	ctsa_link_if.tag                  link,
	input  wire logic                 noise,
	output logic                      usr_rx_valid,
	output logic [7:0]                usr_rx_data,
	output logic                      usr_rx_last,
	input  wire logic                 usr_rx_ready,
	input  wire logic                 usr_tx_valid,
	input  wire logic [7:0]           usr_tx_data,
	input  wire logic                 usr_tx_last,
	output logic                      usr_tx_ack,
	output ctsa_pkg::ctsa_state_t     tag_state,
	output logic [7:0]                tag_id
);
	import ctsa_pkg::*;

	logic [3:0]  s1;
	logic [3:0]  s2;
	logic        clk_prev;
	logic        frm_on;
	logic        rise;
	logic        fr_start;
	logic        fr_end;
	logic        fr_good;
	logic [15:0] lfsr;
	logic [7:0]  rx_sh;
	logic [3:0]  rx_cnt;
	logic        rx_busy;
	logic [7:0]  frm [0:FRAME_MAX-1];
	logic [3:0]  frm_len;
	logic        frm_bad;
	logic [15:0] rx_crc;
	logic [7:0]  cmd;
	logic [7:0]  arg;
	logic        answered;
	ctsa_state_t next_state;
	logic [7:0]  next_id;
	logic        rep_req;
	logic        fwd_req;
	logic        clr_ans;
	logic        set_ans;
	logic        rep_pend;
	logic [7:0]  rep_byte;
	logic [3:0]  fwd_left;
	logic [2:0]  fwd_idx;
	logic        push;
	logic [7:0]  sk_data;
	logic        sk_last;
	logic        sk_valid;
	logic        tx_on;
	logic        tx_usr;
	logic        tx_have;
	logic [8:0]  tx_sh;
	logic [3:0]  tx_cnt;
	ctsa_phase_t tx_phase;
	logic [15:0] tx_crc;
	logic        tx_start;
	logic        tx_load;
	logic [7:0]  tx_byte;

	// Link pins, noise included, pass two flip-flops before use.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1       <= 4'h0;
			s2       <= 4'h0;
			clk_prev <= 1'b0;
			frm_on   <= 1'b0;
		end else begin
			s1       <= {noise, link.link_clk, link.rd_frame, link.rd_data};
			s2       <= s1;
			clk_prev <= s2[2];
			frm_on   <= s2[1];
		end
	end

	assign rise     = s2[2] & ~clk_prev;
	assign fr_start = s2[1] & ~frm_on;
	assign fr_end   = ~s2[1] & frm_on;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lfsr <= LFSR_SEED;
		end else begin
			lfsr <= {lfsr[14:0], (^(lfsr & LFSR_TAPS)) ^ s2[3]};
		end
	end

	// Character capture: hunt for a start bit, take eight data bits, check stop.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_sh   <= 8'h00;
			rx_cnt  <= 4'h0;
			rx_busy <= 1'b0;
			frm_len <= 4'h0;
			frm_bad <= 1'b0;
			rx_crc  <= CRC_INIT;
			for (int i = 0; i < FRAME_MAX; i++) begin
				frm[i] <= 8'h00;
			end
		end else if (fr_start) begin
			frm_len <= 4'h0;
			frm_bad <= 1'b0;
			rx_busy <= 1'b0;
			rx_crc  <= CRC_INIT;
		end else if (rise && s2[1]) begin
			if (!rx_busy) begin
				if (!s2[0]) begin
					rx_busy <= 1'b1;
					rx_cnt  <= 4'h1;
				end
			end else if (rx_cnt == 4'(CHAR_BITS - 1)) begin
				rx_busy <= 1'b0;
				if (!s2[0] || frm_len == 4'(FRAME_MAX)) begin
					frm_bad <= 1'b1;
				end else begin
					frm[frm_len[2:0]] <= rx_sh;
					frm_len           <= frm_len + 4'h1;
					rx_crc            <= crc_step(rx_crc, rx_sh);
				end
			end else begin
				rx_sh  <= {s2[0], rx_sh[7:1]};
				rx_cnt <= rx_cnt + 4'h1;
			end
		end
	end

	assign fr_good = fr_end && !frm_bad && !rx_busy && frm_len >= MIN_FRAME
		&& rx_crc == 16'h0000;
	assign cmd = frm[0];
	assign arg = frm[1];

	always_comb begin
		next_state = tag_state;
		next_id    = tag_id;
		rep_req    = 1'b0;
		fwd_req    = 1'b0;
		clr_ans    = 1'b0;
		set_ans    = 1'b0;
		if (tag_state == ST_OFF) begin
			next_state = ST_READY;
			next_id    = lfsr[7:0];
		end else if (fr_good) begin
			case (tag_state)
				ST_READY: begin
					if (cmd == CMD_BEGIN_INV && frm_len == MIN_FRAME) begin
						next_state = ST_INV;
						rep_req    = 1'b1;
					end
				end
				ST_INV: begin
					if (cmd == CMD_BEGIN_INV && frm_len == MIN_FRAME) begin
						next_id = lfsr[7:0];
						rep_req = 1'b1;
						clr_ans = 1'b1;
					end else if (cmd == CMD_SLOT_ZERO && frm_len == MIN_FRAME) begin
						next_id[3:0] = lfsr[3:0];
						clr_ans      = 1'b1;
						if (lfsr[3:0] == 4'h0) begin
							rep_req = 1'b1;
							set_ans = 1'b1;
						end
					end else if (cmd[7:4] == CMD_SLOT_HI && cmd[3:0] != 4'h0
						&& frm_len == MIN_FRAME) begin
						if (tag_id[3:0] == cmd[3:0] && !answered) begin
							rep_req = 1'b1;
							set_ans = 1'b1;
						end
					end else if (cmd == CMD_CHOOSE && frm_len == CHOOSE_FRAME
						&& arg == tag_id) begin
						next_state = ST_SEL;
						rep_req    = 1'b1;
					end
				end
				ST_SEL: begin
					if (cmd == CMD_CHOOSE && frm_len == CHOOSE_FRAME) begin
						if (arg == tag_id) begin
							rep_req = 1'b1;
						end else begin
							next_state = ST_DESEL;
						end
					end else if (cmd == CMD_FINISH) begin
						next_state = ST_DEACT;
					end else if (cmd == CMD_ROUNDUP) begin
						next_state = ST_INV;
					end else if (cmd == CMD_FETCH || cmd == CMD_STORE || cmd == CMD_UID) begin
						fwd_req = 1'b1;
					end
				end
				ST_DESEL: begin
					if (cmd == CMD_CHOOSE && frm_len == CHOOSE_FRAME && arg == tag_id) begin
						next_state = ST_SEL;
						rep_req    = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Reset is the loss of field: every state falls back to power-off.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tag_state <= ST_OFF;
			tag_id    <= ID_RESET;
			answered  <= 1'b0;
			rep_byte  <= 8'h00;
		end else begin
			tag_state <= next_state;
			tag_id    <= next_id;
			if (set_ans) begin
				answered <= 1'b1;
			end else if (clr_ans) begin
				answered <= 1'b0;
			end
			if (rep_req) begin
				rep_byte <= next_id;
			end
		end
	end

	// Memory requests go to the user through a two-entry skid buffer.
	assign push = fwd_left != 4'h0 && !sk_valid;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fwd_left     <= 4'h0;
			fwd_idx      <= 3'h0;
			usr_rx_valid <= 1'b0;
			usr_rx_data  <= 8'h00;
			usr_rx_last  <= 1'b0;
			sk_valid     <= 1'b0;
			sk_data      <= 8'h00;
			sk_last      <= 1'b0;
		end else begin
			if (fwd_req) begin
				fwd_left <= frm_len - 4'h2;
				fwd_idx  <= 3'h0;
			end else if (push) begin
				fwd_left <= fwd_left - 4'h1;
				fwd_idx  <= fwd_idx + 3'h1;
			end
			if (usr_rx_ready || !usr_rx_valid) begin
				if (sk_valid) begin
					usr_rx_data <= sk_data;
					usr_rx_last <= sk_last;
					sk_valid    <= 1'b0;
				end else begin
					usr_rx_valid <= push;
					usr_rx_data  <= frm[fwd_idx];
					usr_rx_last  <= fwd_left == 4'h1;
				end
			end else if (push) begin
				sk_valid <= 1'b1;
				sk_data  <= frm[fwd_idx];
				sk_last  <= fwd_left == 4'h1;
			end
		end
	end

	assign tx_start = rise && !tx_have && !tx_on
		&& (rep_pend || (tag_state == ST_SEL && usr_tx_valid));

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rep_pend <= 1'b0;
		end else if (rep_req) begin
			rep_pend <= 1'b1;
		end else if (tx_start) begin
			rep_pend <= 1'b0;
		end
	end

	always_comb begin
		tx_load = 1'b0;
		tx_byte = rep_byte;
		if (rise && tx_on && !tx_have) begin
			case (tx_phase)
				PH_DATA: begin
					tx_load = !tx_usr || usr_tx_valid;
					tx_byte = tx_usr ? usr_tx_data : rep_byte;
				end
				PH_CRCL: begin
					tx_load = 1'b1;
					tx_byte = tx_crc[7:0];
				end
				PH_CRCH: begin
					tx_load = 1'b1;
					tx_byte = tx_crc[15:8];
				end
				default: begin
				end
			endcase
		end
	end

	// Reply framing: open, data characters, CRC low, CRC high, close.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_on         <= 1'b0;
			tx_usr        <= 1'b0;
			tx_have       <= 1'b0;
			tx_sh         <= 9'h1ff;
			tx_cnt        <= 4'h0;
			tx_phase      <= PH_DATA;
			tx_crc        <= CRC_INIT;
			usr_tx_ack    <= 1'b0;
			link.tg_frame <= 1'b0;
			link.tg_data  <= 1'b1;
		end else begin
			usr_tx_ack <= tx_load && tx_phase == PH_DATA && tx_usr;
			if (tx_start) begin
				tx_on         <= 1'b1;
				link.tg_frame <= 1'b1;
				tx_usr        <= !rep_pend;
				tx_phase      <= PH_DATA;
				tx_crc        <= CRC_INIT;
			end else if (tx_load) begin
				link.tg_data <= 1'b0;
				tx_sh        <= {1'b1, tx_byte};
				tx_cnt       <= 4'h1;
				tx_have      <= 1'b1;
				if (tx_phase == PH_DATA) begin
					tx_crc <= crc_step(tx_crc, tx_byte);
					if (!tx_usr || usr_tx_last) begin
						tx_phase <= PH_CRCL;
					end
				end else begin
					tx_phase <= tx_phase == PH_CRCL ? PH_CRCH : PH_END;
				end
			end else if (rise && tx_have) begin
				link.tg_data <= tx_sh[0];
				tx_sh        <= {1'b1, tx_sh[8:1]};
				tx_cnt       <= tx_cnt + 4'h1;
				tx_have      <= tx_cnt != 4'(CHAR_BITS - 1);
			end else if (rise && tx_on && tx_phase == PH_END) begin
				tx_on         <= 1'b0;
				link.tg_frame <= 1'b0;
			end
		end
	end
endmodule : ctsa_tag_end

//--- hw/ctsa_reader_end.sv
// Purpose: Reader end: makes the link clock, frames requests, takes replies.
// Assumes: The user keeps to the tag's state sequence and waits for replies.
// Notes:   Replies are passed on byte by byte, CRC bytes included.
`timescale 1ns/1ps
module ctsa_reader_end #(
	parameter int LINK_HALF = ctsa_pkg::LINK_HALF_DEF
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	ctsa_link_if.reader      link,
	input  wire logic        cmd_valid,
	input  wire logic [7:0]  cmd_data,
	input  wire logic        cmd_last,
	output logic             cmd_ack,
	output logic             rsp_valid,
	output logic [7:0]       rsp_data,
	output logic             rsp_end,
	output logic             rsp_ok
);
	import ctsa_pkg::*;

	// Refuse half periods below 8 or above 255 cycles of ref_clk.
	if (LINK_HALF < 8 || LINK_HALF > 255) begin : g_half_check
		$error("LINK_HALF must lie in 8 to 255");
	end

	logic [7:0]  div;
	logic        fall;
	logic [1:0]  r1;
	logic [1:0]  r2;
	logic        rx_on;
	logic        rx_busy;
	logic [3:0]  rx_cnt;
	logic [7:0]  rx_sh;
	logic [3:0]  rx_len;
	logic        rx_bad;
	logic [15:0] rx_crc;
	logic        tx_on;
	logic        tx_have;
	logic [8:0]  tx_sh;
	logic [3:0]  tx_cnt;
	ctsa_phase_t tx_phase;
	logic [15:0] tx_crc;
	logic        tx_load;
	logic [7:0]  tx_byte;

	assign fall = div == 8'(LINK_HALF - 1) && link.link_clk;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div           <= 8'h00;
			link.link_clk <= 1'b0;
		end else if (div == 8'(LINK_HALF - 1)) begin
			div           <= 8'h00;
			link.link_clk <= ~link.link_clk;
		end else begin
			div <= div + 8'h01;
		end
	end

	always_comb begin
		tx_load = 1'b0;
		tx_byte = cmd_data;
		if (fall && tx_on && !tx_have) begin
			case (tx_phase)
				PH_DATA: tx_load = cmd_valid;
				PH_CRCL: begin
					tx_load = 1'b1;
					tx_byte = tx_crc[7:0];
				end
				PH_CRCH: begin
					tx_load = 1'b1;
					tx_byte = tx_crc[15:8];
				end
				default: begin
				end
			endcase
		end
	end

	// Request framing; data changes on the falling link edge.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_on         <= 1'b0;
			tx_have       <= 1'b0;
			tx_sh         <= 9'h1ff;
			tx_cnt        <= 4'h0;
			tx_phase      <= PH_DATA;
			tx_crc        <= CRC_INIT;
			cmd_ack       <= 1'b0;
			link.rd_frame <= 1'b0;
			link.rd_data  <= 1'b1;
		end else begin
			cmd_ack <= tx_load && tx_phase == PH_DATA;
			if (fall && !tx_on && !tx_have && cmd_valid) begin
				tx_on         <= 1'b1;
				link.rd_frame <= 1'b1;
				tx_phase      <= PH_DATA;
				tx_crc        <= CRC_INIT;
			end else if (tx_load) begin
				link.rd_data <= 1'b0;
				tx_sh        <= {1'b1, tx_byte};
				tx_cnt       <= 4'h1;
				tx_have      <= 1'b1;
				if (tx_phase == PH_DATA) begin
					tx_crc <= crc_step(tx_crc, tx_byte);
					if (cmd_last) begin
						tx_phase <= PH_CRCL;
					end
				end else begin
					tx_phase <= tx_phase == PH_CRCL ? PH_CRCH : PH_END;
				end
			end else if (fall && tx_have) begin
				link.rd_data <= tx_sh[0];
				tx_sh        <= {1'b1, tx_sh[8:1]};
				tx_cnt       <= tx_cnt + 4'h1;
				tx_have      <= tx_cnt != 4'(CHAR_BITS - 1);
			end else if (fall && tx_on && tx_phase == PH_END) begin
				tx_on         <= 1'b0;
				link.rd_frame <= 1'b0;
			end
		end
	end

	// Reply capture on the falling link edge, half a period after the tag drives.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			r1        <= 2'b01;
			r2        <= 2'b01;
			rx_on     <= 1'b0;
			rx_busy   <= 1'b0;
			rx_cnt    <= 4'h0;
			rx_sh     <= 8'h00;
			rx_len    <= 4'h0;
			rx_bad    <= 1'b0;
			rx_crc    <= CRC_INIT;
			rsp_valid <= 1'b0;
			rsp_data  <= 8'h00;
			rsp_end   <= 1'b0;
			rsp_ok    <= 1'b0;
		end else begin
			r1        <= {link.tg_frame, link.tg_data};
			r2        <= r1;
			rsp_valid <= 1'b0;
			rsp_end   <= 1'b0;
			if (fall) begin
				rx_on <= r2[1];
				if (r2[1] && !rx_on) begin
					rx_busy <= 1'b0;
					rx_len  <= 4'h0;
					rx_bad  <= 1'b0;
					rx_crc  <= CRC_INIT;
				end else if (!r2[1] && rx_on) begin
					rsp_end <= 1'b1;
					rsp_ok  <= !rx_bad && !rx_busy && rx_len >= MIN_FRAME
						&& rx_crc == 16'h0000;
				end else if (r2[1] && !rx_busy) begin
					if (!r2[0]) begin
						rx_busy <= 1'b1;
						rx_cnt  <= 4'h1;
					end
				end else if (r2[1] && rx_cnt == 4'(CHAR_BITS - 1)) begin
					rx_busy <= 1'b0;
					if (!r2[0]) begin
						rx_bad <= 1'b1;
					end else begin
						rsp_valid <= 1'b1;
						rsp_data  <= rx_sh;
						rx_crc    <= crc_step(rx_crc, rx_sh);
						if (rx_len != 4'hf) begin
							rx_len <= rx_len + 4'h1;
						end
					end
				end else if (r2[1]) begin
					rx_sh  <= {r2[0], rx_sh[7:1]};
					rx_cnt <= rx_cnt + 4'h1;
				end
			end
		end
	end
endmodule : ctsa_reader_end

//--- verif/ctsa_link_sva.sv
// Purpose: Assertions on the link wires and the tag state of the tag link.
// Assumes: One ref_clk domain; all inputs are sampled as plain signals.
// Notes:   LINK_HALF must equal the value given to the reader end.
`timescale 1ns/1ps
module ctsa_link_sva #(
	parameter int LINK_HALF = 8
) (
	input wire logic                  ref_clk,
	input wire logic                  rst_n,
	input wire logic                  link_clk,
	input wire logic                  rd_frame,
	input wire logic                  rd_data,
	input wire logic                  tg_frame,
	input wire logic                  tg_data,
	input wire ctsa_pkg::ctsa_state_t tag_state,
	input wire logic [7:0]            tag_id
);
	import ctsa_pkg::*;
	int tg_len;
	int rd_len;
	default clocking dclk @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// Frame lengths in ref_clk cycles, used to bound the character count.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tg_len <= 0;
			rd_len <= 0;
		end else begin
			tg_len <= tg_frame ? tg_len + 1 : 0;
			rd_len <= rd_frame ? rd_len + 1 : 0;
		end
	end
	a_powerup_ready: assert property (tag_state == ST_OFF |=> tag_state == ST_READY)
		else $error("tag did not reach ready after power-up");
	a_ready_exit: assert property (tag_state == ST_READY |=>
		tag_state inside {ST_READY, ST_INV})
		else $error("tag left ready for a state other than inventory");
	a_inv_exit: assert property (tag_state == ST_INV |=> tag_state inside {ST_INV, ST_SEL})
		else $error("tag left inventory for a wrong state");
	a_desel_exit: assert property (tag_state == ST_DESEL |=>
		tag_state inside {ST_DESEL, ST_SEL})
		else $error("tag left deselected for a wrong state");
	a_deact_sticky: assert property (tag_state == ST_DEACT |=> $stable(tag_state))
		else $error("tag left deactivated while powered");
	a_reply_state: assert property ($rose(tg_frame) |-> tag_state inside {ST_INV, ST_SEL})
		else $error("tag replied from a silent state");
	a_idle_high: assert property ((tg_frame || tg_data) && (rd_frame || rd_data))
		else $error("data line low outside a frame");
	a_start_bit: assert property ($rose(tg_frame) |-> ##[0:40] !tg_data)
		else $error("reply frame opened without a start bit");
	a_reply_length: assert property ($fell(tg_frame) |->
		tg_len >= (3 * CHAR_BITS - 1) * 2 * LINK_HALF)
		else $error("reply frame shorter than three characters");
	a_request_length: assert property ($fell(rd_frame) |->
		rd_len inside {[(3 * CHAR_BITS - 1) * 2 * LINK_HALF :
		(FRAME_MAX * CHAR_BITS + 3) * 2 * LINK_HALF]})
		else $error("request frame length out of range");
	a_id_quiet: assert property ($changed(tag_id) |->
		!rd_frame && !tg_frame && tag_state inside {ST_READY, ST_INV})
		else $error("identifier changed outside ready or inventory");
	a_link_steady: assert property ($changed(link_clk) |=> $stable(link_clk) [*7])
		else $error("link clock changed within a half period");
endmodule : ctsa_link_sva

//--- verif/test_contactless_tag_state_anticollision.sv
// Purpose: Self-checking bench joining the reader end and the tag end.
// Assumes: Reply windows are sized for a LINK_HALF of 8.
// Notes:   Noise, payloads and receive stalls come from a fixed seed.
`timescale 1ns/1ps
module test_contactless_tag_state_anticollision;
	import ctsa_pkg::*;
	localparam int LH = 8;
	logic        ref_clk      = 1'b0;
	logic        rst_n        = 1'b0;
	logic        noise        = 1'b0;
	logic        cmd_valid    = 1'b0;
	logic [7:0]  cmd_data     = 8'h00;
	logic        cmd_last     = 1'b0;
	logic        cmd_ack;
	logic        rsp_valid;
	logic [7:0]  rsp_data;
	logic        rsp_end;
	logic        rsp_ok;
	logic        usr_rx_valid;
	logic [7:0]  usr_rx_data;
	logic        usr_rx_last;
	logic        usr_rx_ready = 1'b0;
	logic        usr_tx_valid = 1'b0;
	logic [7:0]  usr_tx_data  = 8'h00;
	logic        usr_tx_last  = 1'b0;
	logic        usr_tx_ack;
	ctsa_state_t tag_state;
	logic [7:0]  tag_id;
	int          seed         = 12;
	int          miscompares  = 0;
	int          n_compared   = 0;
	logic        rx_hold      = 1'b0;
	logic        r;
	logic        got;
	logic        ok;
	logic [7:0]  id;
	logic [3:0]  nib;
	logic [7:0]  cb[8];
	logic [7:0]  rq[$];
	logic [8:0]  rxq[$];
	logic [7:0]  ign[5]       = '{CMD_BEGIN_INV, CMD_SLOT_ZERO, CMD_CHOOSE, CMD_FETCH, CMD_ROUNDUP};

	ctsa_link_if ctsa_link_if_inst ();
	ctsa_reader_end #(.LINK_HALF(LH)) ctsa_reader_end_inst (.ref_clk, .rst_n,
		.link(ctsa_link_if_inst), .cmd_valid, .cmd_data, .cmd_last, .cmd_ack,
		.rsp_valid, .rsp_data, .rsp_end, .rsp_ok);
	ctsa_tag_end ctsa_tag_end_inst (.ref_clk, .rst_n, .link(ctsa_link_if_inst), .noise,
		.usr_rx_valid, .usr_rx_data, .usr_rx_last, .usr_rx_ready, .usr_tx_valid,
		.usr_tx_data, .usr_tx_last, .usr_tx_ack, .tag_state, .tag_id);
	ctsa_link_sva #(.LINK_HALF(LH)) ctsa_link_sva_inst (.ref_clk, .rst_n,
		.link_clk(ctsa_link_if_inst.link_clk), .rd_frame(ctsa_link_if_inst.rd_frame),
		.rd_data(ctsa_link_if_inst.rd_data), .tg_frame(ctsa_link_if_inst.tg_frame),
		.tg_data(ctsa_link_if_inst.tg_data), .tag_state, .tag_id);

	always #4 ref_clk = ~ref_clk;

	// A byte is recorded when ready is driven high while valid is shown.
	always @(negedge ref_clk) begin
		noise <= 1'($random(seed));
		r = !rx_hold && ($random(seed) % 3 != 0);
		usr_rx_ready <= r;
		if (r && usr_rx_valid === 1'b1) rxq.push_back({usr_rx_last, usr_rx_data});
	end

	task automatic conclude();
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude

	task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask : chk8

	task automatic chks(input string what, input ctsa_state_t e, input ctsa_state_t g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask : chks

	task automatic wait_ack(input bit tx);
		int k;
		k = 0;
		do begin
			@(negedge ref_clk);
			k++;
		end while ((tx ? usr_tx_ack : cmd_ack) !== 1'b1 && k < 400);
		if (k >= 400) begin
			chk8("handshake", 8'h01, 8'h00);
			conclude();
		end
	endtask : wait_ack

	task automatic send(input int n);
		for (int i = 0; i < n; i++) begin
			cmd_valid <= 1'b1;
			cmd_data  <= cb[i];
			cmd_last  <= (i == n - 1);
			wait_ack(1'b0);
		end
		cmd_valid <= 1'b0;
		cmd_last  <= 1'b0;
	endtask : send

	task automatic listen();
		rq.delete();
		got = 1'b0;
		for (int k = 0; k < 1500 && !got; k++) begin
			@(negedge ref_clk);
			if (rsp_valid === 1'b1) rq.push_back(rsp_data);
			got = (rsp_end === 1'b1);
			ok  = rsp_ok;
		end
	endtask : listen

	task automatic chk_frame(input int n);
		logic [15:0] c;
		c = CRC_INIT;
		chk8("reply length", 8'(n + 2), 8'(rq.size()));
		for (int i = 0; i < n && i < rq.size(); i++) begin
			c = c ^ {8'h00, rq[i]};
			for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		end
		if (rq.size() == n + 2) begin
			chk8("crc low", c[7:0], rq[n]);
			chk8("crc high", c[15:8], rq[n + 1]);
		end
		chk8("reply ok", 8'h01, {7'h0, ok});
	endtask : chk_frame

	task automatic run(input logic [7:0] c, input logic [7:0] a, input logic e, input ctsa_state_t s);
		cb[0] = c;
		cb[1] = a;
		send(c == CMD_CHOOSE ? 2 : 1);
		listen();
		chk8("reply present", {7'h0, e}, {7'h0, got});
		chks("tag state", s, tag_state);
		if (e && !got) conclude();
		if (got) chk_frame(1);
	endtask : run

	task automatic mem(input logic [7:0] c, input int n, input logic hold);
		logic [7:0] tx0;
		logic [7:0] tx1;
		cb[0] = c;
		for (int i = 1; i < n; i++) cb[i] = 8'($random(seed));
		tx0 = 8'($random(seed));
		tx1 = 8'($random(seed));
		rxq.delete();
		rx_hold <= hold;
		send(n);
		repeat (600) @(negedge ref_clk);
		if (hold) chk8("held byte valid", 8'h01, {7'h0, usr_rx_valid});
		rx_hold <= 1'b0;
		for (int k = 0; k < 300 && rxq.size() < n; k++) @(negedge ref_clk);
		chk8("request bytes", 8'(n), 8'(rxq.size()));
		for (int i = 0; i < n && i < rxq.size(); i++) chk8("request byte", cb[i], rxq[i][7:0]);
		if (rxq.size() == n) chk8("request last", 8'h01, {7'h0, rxq[n - 1][8]});
		if (rxq.size() < n) conclude();
		fork
			begin
				usr_tx_valid <= 1'b1;
				usr_tx_data  <= tx0;
				wait_ack(1'b1);
				usr_tx_data  <= tx1;
				usr_tx_last  <= 1'b1;
				wait_ack(1'b1);
				usr_tx_valid <= 1'b0;
				usr_tx_last  <= 1'b0;
			end
			listen();
		join
		chk8("reply present", 8'h01, {7'h0, got});
		if (!got) conclude();
		chk_frame(2);
		chk8("reply byte", tx0, rq[0]);
		chk8("reply byte", tx1, rq[1]);
	endtask : mem

	initial begin
		repeat (6) @(negedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(negedge ref_clk);
		chks("state after power-up", ST_READY, tag_state);
		for (int i = 1; i < 5; i++) run(ign[i], tag_id, 1'b0, ST_READY);
		run(CMD_BEGIN_INV, 8'h00, 1'b1, ST_INV);
		chk8("identifier", tag_id, rq[0]);
		run(CMD_BEGIN_INV, 8'h00, 1'b1, ST_INV);
		id = rq[0];
		chk8("identifier", tag_id, id);
		run(8'h0a, 8'h00, 1'b0, ST_INV);
		cb[0] = CMD_SLOT_ZERO;
		send(1);
		listen();
		nib = tag_id[3:0];
		chk8("slot zero reply", {7'h0, nib == 4'h0}, {7'h0, got});
		if (got) chk8("slot zero id", {id[7:4], 4'h0}, rq[0]);
		chks("state after slot zero", ST_INV, tag_state);
		for (int s = 1; s < 16; s++) begin
			run({CMD_SLOT_HI, 4'(s)}, 8'h00, nib == 4'(s), ST_INV);
			if (got) begin
				chk8("slot id", {id[7:4], nib}, rq[0]);
				run({CMD_SLOT_HI, 4'(s)}, 8'h00, 1'b0, ST_INV);
			end
		end
		id = tag_id;
		run(CMD_CHOOSE, id ^ 8'h01, 1'b0, ST_INV);
		run(CMD_CHOOSE, id, 1'b1, ST_SEL);
		chk8("chosen id", id, rq[0]);
		run(CMD_SLOT_ZERO, 8'h00, 1'b0, ST_SEL);
		run(CMD_BEGIN_INV, 8'h00, 1'b0, ST_SEL);
		mem(CMD_STORE, 6, 1'b1);
		mem(CMD_FETCH, 2, 1'b0);
		mem(CMD_UID, 1, 1'b0);
		run(CMD_CHOOSE, id, 1'b1, ST_SEL);
		chk8("chosen id", id, rq[0]);
		run(CMD_CHOOSE, id ^ 8'h80, 1'b0, ST_DESEL);
		run(CMD_BEGIN_INV, 8'h00, 1'b0, ST_DESEL);
		run(CMD_CHOOSE, id, 1'b1, ST_SEL);
		run(CMD_ROUNDUP, 8'h00, 1'b0, ST_INV);
		run(CMD_CHOOSE, id, 1'b1, ST_SEL);
		run(CMD_FINISH, 8'h00, 1'b0, ST_DEACT);
		for (int i = 0; i < 5; i++) run(ign[i], id, 1'b0, ST_DEACT);
		rst_n <= 1'b0;
		repeat (3) @(negedge ref_clk);
		chks("state without field", ST_OFF, tag_state);
		rst_n <= 1'b1;
		repeat (3) @(negedge ref_clk);
		chks("state after field return", ST_READY, tag_state);
		run(CMD_BEGIN_INV, 8'h00, 1'b1, ST_INV);
		conclude();
	end
endmodule : test_contactless_tag_state_anticollision
